// [rtl/ppif_cfg.svh]
// constants for the parallel pixel input stage and its serial framer
// assumes one system clock; all pins arrive synchronous to it
//
// Summary of operation
// - with filter code 01 a de or hsync pulse under 3 capture edges is dropped; vsync is never filtered
// - with filter code 00 control changes pass with no width limit
// - captured 24-bit word leaves as one serial stream with embedded clock
// - a 3-bit slow control bus travels beside the pixel data
// - payload is scrambled in codes 00 and 01, and dc balanced in all codes but 11, before it is sent
// - capture on rising parallel clock when edge select is 1, falling when 0
// - codes 10 and 11 are compatibility modes; 00 and 01 are normal
`ifndef PPIF_CFG_SVH
`define PPIF_CFG_SVH

`define PPIF_PIX_W      24
`define PPIF_CTL_W      3
`define PPIF_PAY_W      27
`define PPIF_FRAME_W    30
`define PPIF_CNT_W      5
`define PPIF_FRAME_LAST 5'h1D
`define PPIF_CNT_ZERO   5'h00
`define PPIF_PAY_DISP   7'sd27
`define PPIF_RD_LIMIT   8'sd40
`define PPIF_RD_RESET   8'sh00
`define PPIF_LFSR_W     31
`define PPIF_LFSR_SEED  31'h5A5A_1234
`define PPIF_LFSR_TAP   27
`define PPIF_FILT_MASK  3'h3
`define PPIF_HIST_W     2

`endif

// [rtl/ppif_pkg.sv]
// types shared by the parallel pixel input stage
// assumes ppif_cfg.svh is compiled alongside
package ppif_pkg;

  typedef enum logic [1:0] {
    PPIF_FILT_OFF = 2'h0,
    PPIF_FILT_ON  = 2'h1,
    PPIF_COMPAT_A = 2'h2,
    PPIF_COMPAT_B = 2'h3
  } ppif_mode_t;

  typedef enum logic [1:0] {
    PPIF_IDLE = 2'b01,
    PPIF_SEND = 2'b10
  } ppif_state_t;

endpackage

// [rtl/ppif_ctl_filter.sv]
// minimum pulse filter for one control line
// assumes sample_en marks the capture edges of the parallel clock
`timescale 1ns/100ps
`include "ppif_cfg.svh"

module ppif_ctl_filter (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic sample_en,
  input  wire logic filter_on,
  input  wire logic din,
  output logic      dout
);

  logic [`PPIF_HIST_W-1:0] hist_reg;
  logic [`PPIF_HIST_W-1:0] hist_next;
  logic                    dout_reg;
  logic                    dout_next;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    hist_next = hist_reg;
    dout_next = dout_reg;
    if (sample_en) begin
      hist_next = {hist_reg[0], din};
      if (!filter_on) begin
        dout_next = din;
      end else if ((din == hist_reg[0]) && (din == hist_reg[1])) begin
        dout_next = din;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hist_reg <= '0;
      dout_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;

  //////////////////////////////////////////////////////////////////////////////
  filt_bypass_a : assert property (@(posedge clock) disable iff (sys_rst)
    sample_en && !filter_on |=> dout_reg == $past(din))
    else $error("unfiltered control level not forwarded");

  filt_short_drop_a : assert property (@(posedge clock) disable iff (sys_rst)
    sample_en && filter_on && (din != hist_reg[0]) |=> dout_reg == $past(dout_reg))
    else $error("short control pulse passed the filter");

  filt_stable_a : assert property (@(posedge clock) disable iff (sys_rst)
    $changed(dout_reg) && $past(filter_on) |->
      (hist_reg[0] == dout_reg) && (hist_reg[1] == dout_reg)
      && ($past(hist_reg[1]) == dout_reg))
    else $error("filter changed without three equal samples");

endmodule

// [rtl/ppif_top.sv]
// parallel pixel capture, control filtering and serial framing
// assumes parallel_clk and all pixel pins are synchronous to clock and that
// the parallel clock runs slow enough for one 30-bit frame per pixel
`timescale 1ns/100ps
`include "ppif_cfg.svh"

module ppif_top (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    parallel_clk,
  input  wire logic                    capture_edge_sel,
  input  wire ppif_pkg::ppif_mode_t    config_mode,
  input  wire logic [`PPIF_PIX_W-1:0]  pixel_in,
  input  wire logic                    data_enable_in,
  input  wire logic                    hsync_in,
  input  wire logic                    vsync_in,
  output logic [`PPIF_PIX_W-1:0]       pixel_word,
  output logic [`PPIF_CTL_W-1:0]       ctl_word,
  output logic                         word_valid,
  output logic                         serial_out,
  output logic                         frame_start
);

  import ppif_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // capture group
  logic                   pclk_prev_reg;
  logic                   pclk_prev_next;
  logic [`PPIF_PIX_W-1:0] pixel_word_reg;
  logic [`PPIF_PIX_W-1:0] pixel_word_next;
  logic                   word_valid_reg;
  logic                   word_valid_next;
  logic                   pend_reg;
  logic                   pend_next;
  logic                   capture_strobe;
  logic [`PPIF_CTL_W-1:0] ctl_raw;
  logic [`PPIF_CTL_W-1:0] ctl_filt;
  logic                   filter_en;
  logic                   load_frame;

  // a macro literal cannot be bit-selected, so the mask lives in a named constant
  localparam logic [`PPIF_CTL_W-1:0] filt_mask = `PPIF_FILT_MASK;

  assign ctl_raw   = {vsync_in, hsync_in, data_enable_in};
  assign filter_en = (config_mode == PPIF_FILT_ON);

  always_comb begin
    capture_strobe = capture_edge_sel ? (parallel_clk && !pclk_prev_reg)
                                      : (!parallel_clk && pclk_prev_reg);
  end

  // vsync is never filtered: it is slow by contract and needs no deglitching
  genvar gi;
  generate
    for (gi = 0; gi < `PPIF_CTL_W; gi++) begin : g_filt
      ppif_ctl_filter u_filt (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .sample_en (capture_strobe),
        .filter_on (filter_en && filt_mask[gi]),
        .din       (ctl_raw[gi]),
        .dout      (ctl_filt[gi])
      );
    end
  endgenerate

  always_comb begin
    pclk_prev_next  = parallel_clk;
    pixel_word_next = pixel_word_reg;
    word_valid_next = 1'b0;
    pend_next       = pend_reg;
    if (load_frame) begin
      pend_next = 1'b0;
    end
    if (capture_strobe) begin
      pixel_word_next = pixel_in;
      word_valid_next = 1'b1;
      pend_next       = 1'b1; // new word wins over a same-cycle load
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pclk_prev_reg  <= 1'b0;
      pixel_word_reg <= '0;
      word_valid_reg <= 1'b0;
      pend_reg       <= 1'b0;
    end else begin
      pclk_prev_reg  <= pclk_prev_next;
      pixel_word_reg <= pixel_word_next;
      word_valid_reg <= word_valid_next;
      pend_reg       <= pend_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame group
  ppif_state_t               state_reg;
  ppif_state_t               state_next;
  logic [`PPIF_FRAME_W-1:0]  shift_reg;
  logic [`PPIF_FRAME_W-1:0]  shift_next;
  logic [`PPIF_CNT_W-1:0]    cnt_reg;
  logic [`PPIF_CNT_W-1:0]    cnt_next;
  logic [`PPIF_LFSR_W-1:0]   lfsr_reg;
  logic [`PPIF_LFSR_W-1:0]   lfsr_next;
  logic signed [7:0]         rd_reg;
  logic signed [7:0]         rd_next;
  logic                      serial_reg;
  logic                      serial_next;
  logic                      frame_start_reg;
  logic                      frame_start_next;
  logic [`PPIF_PAY_W-1:0]    payload;
  logic [`PPIF_PAY_W-1:0]    scrambled;
  logic [`PPIF_PAY_W-1:0]    body;
  logic signed [6:0]         word_disp;
  logic                      invert;
  logic [`PPIF_FRAME_W-1:0]  frame;
  logic                      scramble_on;
  logic                      balance_on;

  function automatic logic [4:0] ppif_ones(input logic [`PPIF_PAY_W-1:0] w);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < `PPIF_PAY_W; i++) begin
      n = n + 5'(w[i]);
    end
    return n;
  endfunction

  assign payload     = {ctl_filt, pixel_word_reg};
  assign scramble_on = (config_mode == PPIF_FILT_OFF) || (config_mode == PPIF_FILT_ON);
  assign balance_on  = (config_mode != PPIF_COMPAT_B);

  always_comb begin
    scrambled = scramble_on ? (payload ^ lfsr_reg[`PPIF_PAY_W-1:0]) : payload;
    word_disp = $signed({1'b0, ppif_ones(scrambled), 1'b0}) - `PPIF_PAY_DISP;
    invert    = balance_on && (((rd_reg > 0) && (word_disp > 0))
                               || ((rd_reg < 0) && (word_disp < 0)));
    body      = invert ? ~scrambled : scrambled;
    // start high, stop low: every frame carries a rising edge for clock recovery
    frame     = {1'b1, invert, body, 1'b0};
    load_frame = pend_reg && ((state_reg == PPIF_IDLE) || (cnt_reg == `PPIF_CNT_ZERO));
  end

  always_comb begin
    state_next       = state_reg;
    shift_next       = shift_reg;
    cnt_next         = cnt_reg;
    lfsr_next        = lfsr_reg;
    rd_next          = rd_reg;
    serial_next      = 1'b0;
    frame_start_next = 1'b0;
    if (load_frame) begin
      state_next       = PPIF_SEND;
      serial_next      = frame[`PPIF_FRAME_W-1];
      shift_next       = {frame[`PPIF_FRAME_W-2:0], 1'b0};
      cnt_next         = `PPIF_FRAME_LAST;
      frame_start_next = 1'b1;
      lfsr_next        = {lfsr_reg[`PPIF_LFSR_W-2:0],
                          lfsr_reg[`PPIF_LFSR_W-1] ^ lfsr_reg[`PPIF_LFSR_TAP]};
      if (balance_on) begin
        rd_next = rd_reg + (invert ? -8'(word_disp) : 8'(word_disp))
                  + (invert ? 8'sd1 : -8'sd1);
      end
    end else begin
      unique case (state_reg)
        PPIF_IDLE: begin
          state_next = PPIF_IDLE;
        end
        PPIF_SEND: begin
          if (cnt_reg == `PPIF_CNT_ZERO) begin
            state_next = PPIF_IDLE;
          end else begin
            serial_next = shift_reg[`PPIF_FRAME_W-1];
            shift_next  = {shift_reg[`PPIF_FRAME_W-2:0], 1'b0};
            cnt_next    = cnt_reg - 5'h01;
          end
        end
        default: begin
          state_next = PPIF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg       <= PPIF_IDLE;
      shift_reg       <= '0;
      cnt_reg         <= `PPIF_CNT_ZERO;
      lfsr_reg        <= `PPIF_LFSR_SEED;
      rd_reg          <= `PPIF_RD_RESET;
      serial_reg      <= 1'b0;
      frame_start_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      shift_reg       <= shift_next;
      cnt_reg         <= cnt_next;
      lfsr_reg        <= lfsr_next;
      rd_reg          <= rd_next;
      serial_reg      <= serial_next;
      frame_start_reg <= frame_start_next;
    end
  end

  assign pixel_word  = pixel_word_reg;
  assign ctl_word    = ctl_filt;
  assign word_valid  = word_valid_reg;
  assign serial_out  = serial_reg;
  assign frame_start = frame_start_reg;

  //////////////////////////////////////////////////////////////////////////////
  capture_edge_a : assert property (@(posedge clock) disable iff (sys_rst)
    word_valid_reg |-> ($past(parallel_clk) == $past(capture_edge_sel))
      && ($past(parallel_clk, 2) != $past(parallel_clk)))
    else $error("word captured on the wrong parallel clock edge");

  pixel_capture_a : assert property (@(posedge clock) disable iff (sys_rst)
    word_valid_reg |-> pixel_word_reg == $past(pixel_in))
    else $error("captured pixel word differs from the pins");

  frame_bounds_a : assert property (@(posedge clock) disable iff (sys_rst)
    frame_start_reg |-> serial_reg ##29 !serial_reg)
    else $error("frame lacks its start or stop bit");

  frame_spacing_a : assert property (@(posedge clock) disable iff (sys_rst)
    frame_start_reg |=> !frame_start_reg [*8])
    else $error("frames start too close together");

  ctl_carried_a : assert property (@(posedge clock) disable iff (sys_rst)
    frame_start_reg && ($past(config_mode) == PPIF_COMPAT_B)
      |-> shift_reg[28:26] == $past(ctl_filt))
    else $error("control bits missing from the frame");

  balance_bound_a : assert property (@(posedge clock) disable iff (sys_rst)
    (rd_reg <= `PPIF_RD_LIMIT) && (rd_reg >= -`PPIF_RD_LIMIT))
    else $error("running disparity out of bounds");

  balance_flag_a : assert property (@(posedge clock) disable iff (sys_rst)
    frame_start_reg && (($past(rd_reg) > 0) == (shift_reg[29] == 1'b0))
      && ($past(rd_reg) != 0) && $past(balance_on) |-> rd_reg <= $past(rd_reg) + 8'sd28)
    else $error("disparity grew past one frame");

  compat_plain_a : assert property (@(posedge clock) disable iff (sys_rst)
    load_frame && !scramble_on && !invert |=> shift_reg[28:2] == $past(payload))
    else $error("compatibility mode scrambled the payload");

endmodule

// [testbench/ppif_src_model.sv]
// video source model: drives the parallel clock, pixel word and control lines
// assumes the caller spaces control changes; data shows only at the chosen edge
`timescale 1ns/100ps
`include "ppif_cfg.svh"

module ppif_src_model (
  input  wire logic                   clock,
  output logic                        parallel_clk,
  output logic [`PPIF_PIX_W-1:0]      pixel_in,
  output logic                        data_enable_in,
  output logic                        hsync_in,
  output logic                        vsync_in
);
  initial begin
    parallel_clk = 1'b0;
    pixel_in = 24'h000000;
    {vsync_in, hsync_in, data_enable_in} = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one parallel clock period; h clocks per phase keeps it under 5 MHz
  task automatic send(input logic sel, input logic [7:0] r, input logic [7:0] g,
                      input logic [7:0] b, input logic [2:0] ctl, input int h);
    logic [23:0] d;
    d = {b, g, r};
    @(posedge clock);
    pixel_in <= sel ? d : ~d;
    {vsync_in, hsync_in, data_enable_in} <= ctl;
    repeat (h) @(posedge clock);
    parallel_clk <= 1'b1;
    repeat (h) @(posedge clock);
    parallel_clk <= 1'b0;
    pixel_in <= sel ? ~d : d;
    repeat (h) @(posedge clock);
    // hold has run out: the bus inverts; with sel 0 it no longer shows the word, with sel 1 it shows it again
    pixel_in <= ~pixel_in;
  endtask
endmodule

// [testbench/tb.sv]
// bench for the parallel pixel input stage: table rows, filter, reset
// assumes ppif_src_model drives every pixel-side input
`timescale 1ns/100ps
`include "ppif_cfg.svh"

module tb;
  import ppif_pkg::*;
  typedef struct packed {
    ppif_mode_t  mode;
    logic        sel;
    logic [23:0] pix;
    logic [2:0]  ctl;
  } ppif_row_t;
  localparam ppif_row_t ROWS [6] = '{
    '{PPIF_COMPAT_B, 1'b1, 24'h0F3CA5, 3'h0}, '{PPIF_COMPAT_B, 1'b0, 24'hFF8001, 3'h1},
    '{PPIF_COMPAT_A, 1'b1, 24'h563412, 3'h2}, '{PPIF_COMPAT_A, 1'b0, 24'hBADCFE, 3'h4},
    '{PPIF_FILT_OFF, 1'b1, 24'h00AA55, 3'h7}, '{PPIF_FILT_ON,  1'b0, 24'h7F0180, 3'h7}};
  logic        clock, sys_rst, capture_edge_sel, parallel_clk;
  logic        data_enable_in, hsync_in, vsync_in, word_valid, serial_out, frame_start;
  ppif_mode_t  config_mode;
  logic [23:0] pixel_in, pixel_word, seen_pix;
  logic [2:0]  ctl_word, seen_ctl, prev_ctl;
  logic [29:0] frame_reg;
  int          err_total, num_checks, nbit, fcnt;

  ppif_top ppif_top_inst (.clock(clock), .sys_rst(sys_rst), .parallel_clk(parallel_clk),
    .capture_edge_sel(capture_edge_sel), .config_mode(config_mode), .pixel_in(pixel_in),
    .data_enable_in(data_enable_in), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .pixel_word(pixel_word), .ctl_word(ctl_word), .word_valid(word_valid),
    .serial_out(serial_out), .frame_start(frame_start));
  ppif_src_model ppif_src_model_inst (.clock(clock), .parallel_clk(parallel_clk),
    .pixel_in(pixel_in), .data_enable_in(data_enable_in), .hsync_in(hsync_in),
    .vsync_in(vsync_in));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  // latch each captured word and gather each 30-bit frame msb first
  always @(posedge clock) begin
    if (word_valid === 1'b1) begin
      seen_pix <= pixel_word;
      seen_ctl <= ctl_word;
    end
    if (sys_rst === 1'b1) begin
      nbit <= 0;
    end else if (frame_start === 1'b1) begin
      frame_reg <= {29'h0, serial_out};
      nbit <= 1;
    end else if (nbit != 0) begin
      frame_reg <= {frame_reg[28:0], serial_out};
      nbit <= (nbit == 29) ? 0 : nbit + 1;
      if (nbit == 29) fcnt <= fcnt + 1;
    end
  end

  task automatic check(input string name, input logic [26:0] exp, input logic [26:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // 130 steady periods keep control toggles within the source's allowance
  task automatic idle(input logic [2:0] ctl);
    for (int n = 0; n < 130; n++) ppif_src_model_inst.send(capture_edge_sel, 8'(n), 8'h0F,
                                                           8'hF0, ctl, 2);
  endtask

  task automatic pulse(input logic [2:0] ctl, input int n, input logic [2:0] exp);
    repeat (n) ppif_src_model_inst.send(1'b1, 8'h11, 8'h22, 8'h33, ctl, 2);
    check("ctl_word", 27'(exp), 27'(seen_ctl));
  endtask

  // send one word, wait for its frame, then check capture and frame bits;
  // steps is the number of frames sent since the last reset
  task automatic word_chk(input ppif_row_t r, input int h, input int steps);
    logic [`PPIF_LFSR_W-1:0] lf;
    logic [26:0]             raw;
    int                      base;
    lf   = `PPIF_LFSR_SEED;
    raw  = {r.ctl, r.pix};
    base = fcnt;
    repeat (steps) lf = {lf[`PPIF_LFSR_W-2:0], lf[`PPIF_LFSR_W-1] ^ lf[`PPIF_LFSR_TAP]};
    if (r.mode == PPIF_COMPAT_A || r.mode == PPIF_COMPAT_B) lf = '0;
    ppif_src_model_inst.send(r.sel, r.pix[7:0], r.pix[15:8], r.pix[23:16], r.ctl, h);
    for (int k = 0; k < 80 && fcnt == base; k++) @(posedge clock);
    if (fcnt == base) begin
      $display("MISMATCH frame expected done seen none");
      err_total++;
      finish_test();
    end
    check("pixel_word", 27'(r.pix), 27'(seen_pix));
    check("ctl_word", 27'(r.ctl), 27'(seen_ctl));
    check("start stop", 27'h2, 27'({frame_reg[29], frame_reg[0]}));
    if (r.mode == PPIF_COMPAT_B) check("flag", 27'h0, 27'(frame_reg[28]));
    check("payload", raw ^ lf[26:0] ^ {27{frame_reg[28]}}, frame_reg[27:1]);
  endtask

  initial begin
    sys_rst = 1'b1;
    capture_edge_sel = 1'b1;
    config_mode = PPIF_FILT_OFF;
    {err_total, num_checks, nbit, fcnt} = '0;
    prev_ctl = 3'h0;
    repeat (11) @(posedge clock);
    @(negedge clock);
    check("reset pixel", 27'h0, 27'(pixel_word));
    check("reset outs", 27'h0, 27'({ctl_word, word_valid, serial_out, frame_start}));
    @(posedge clock);
    sys_rst <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge clock);
      config_mode <= ROWS[i].mode;
      capture_edge_sel <= ROWS[i].sel;
      idle(prev_ctl);
      // let the last idle frame drain, so the next frame counted is this row's own
      repeat (70) @(posedge clock);
      word_chk(ROWS[i], (i % 2) ? 6 : 2, fcnt);
      prev_ctl = ROWS[i].ctl;
    end
    $display("test rows done");
    @(posedge clock);
    config_mode <= PPIF_FILT_ON;
    capture_edge_sel <= 1'b1;
    idle(3'h0);
    pulse(3'h3, 2, 3'h0);
    pulse(3'h0, 1, 3'h0);
    idle(3'h0);
    pulse(3'h3, 2, 3'h0);
    pulse(3'h3, 1, 3'h3);
    idle(3'h3);
    pulse(3'h0, 3, 3'h0);
    @(posedge clock);
    config_mode <= PPIF_FILT_OFF;
    idle(3'h0);
    pulse(3'h3, 1, 3'h3);
    pulse(3'h0, 1, 3'h0);
    $display("test filter done");
    ppif_src_model_inst.send(1'b1, 8'hC3, 8'h3C, 8'h99, 3'h0, 2);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("reset pixel", 27'h0, 27'(pixel_word));
    check("reset outs", 27'h0, 27'({ctl_word, word_valid, serial_out, frame_start}));
    @(posedge clock);
    sys_rst <= 1'b0;
    // lfsr and disparity restart: the first frame uses the seed and is never inverted
    word_chk(ppif_row_t'{PPIF_FILT_OFF, 1'b1, 24'h3C5AC3, 3'h0}, 2, 0);
    check("reset flag", 27'h0, 27'(frame_reg[28]));
    $display("test reset done");
    finish_test();
  end
endmodule
